/* File: rtl/fhp_consts.vh */
`ifndef FHP_CONSTS_VH
`define FHP_CONSTS_VH

// register byte offsets
`define FHP_A_CTRL       8'h00
`define FHP_A_HDRCFG     8'h04
`define FHP_A_NET_DEST   8'h08
`define FHP_A_NET_SRC    8'h0c
`define FHP_A_VALIDITY   8'h10
`define FHP_A_PAYLEN     8'h14
`define FHP_A_RXSTAT     8'h18
`define FHP_A_INT_STAT   8'h1c
`define FHP_A_INT_MASK   8'h20

// control register bits
`define FHP_CTRL_START   0
`define FHP_CTRL_PREEN   1
`define FHP_CTRL_REFUSE  2
`define FHP_CTRL_BUSY    3
`define FHP_CTRL_MCERR   4
`define FHP_CTRL_MCTERM  5

// header config bits (same positions as data_field_control minus 16)
`define FHP_CFG_NET      5
`define FHP_CFG_ASSOC    4

// interrupt event bits
`define FHP_EV_TX_DONE   0
`define FHP_EV_RX_FRAME  1
`define FHP_EV_BAD_AUTH  2
`define FHP_EV_BAD_CODE  3
`define FHP_EV_REJ_SENT  4
`define FHP_EV_RX_MCAST  5
`define FHP_EV_W         6

// first-word frame kinds on the stream, bits 31:24
`define FHP_K_DATA       8'h00
`define FHP_K_BUSY       8'h01
`define FHP_K_REJECT     8'h02
`define FHP_K_PREEMPT    8'h03

// reason codes
`define FHP_RJ_REFUSED   8'h20
`define FHP_RJ_NOT_EN    8'h21
`define FHP_RJ_MC_ERR    8'h22
`define FHP_RJ_MC_TERM   8'h23
`define FHP_BSY_PARTIAL  8'h07

// authority codes
`define FHP_AUTH_IGNORED 4'h0
`define FHP_AUTH_IP      4'h4
`define FHP_AUTH_WD_A    4'hc
`define FHP_AUTH_WD_B    4'he

// section lengths in 32-bit words, then the validity byte mask
`define FHP_RSVD_WORDS   9'd4
`define FHP_NET_WORDS    9'd4
`define FHP_ASSOC_WORDS  9'd8
`define FHP_VALID_RSVD   8'hf1

`endif

/* File: rtl/fhp_classify.v */
`timescale 1ns/100ps
`include "fhp_consts.vh"

module fhp_classify (
   // fields under test
   input  wire [3:0] dest_auth,
   input  wire [3:0] src_auth,
   input  wire [7:0] reason,
   input  wire [7:0] kind,
   // verdicts
   output reg        auth_bad,
   output reg        code_bad
);

   // withdrawn and reserved codes alike carry no defined format
   function auth_undefined;
      input [3:0] a;
      begin
         auth_undefined = (a > `FHP_AUTH_IP);
      end
   endfunction

   always @* begin
      auth_bad = auth_undefined(dest_auth) | auth_undefined(src_auth);
      code_bad = 1'b0;
      case (kind)
         `FHP_K_BUSY:
            code_bad = !(reason == 8'h01 || reason == 8'h03 ||
                         reason == `FHP_BSY_PARTIAL || reason == 8'hff);
         `FHP_K_REJECT:
            code_bad = (reason == 8'h00) || (reason > `FHP_RJ_MC_TERM);
         default:
            code_bad = 1'b0;
      endcase
   end

endmodule

/* File: rtl/fhp_host.v */
`timescale 1ns/100ps
`include "fhp_consts.vh"

// What this block does
// - with any optional header, a 16-byte reserved region leads the data field.
// - present headers follow it in order: network, association, device.
// - with no optional header, no space is reserved; payload starts first.
// - header presence comes only from data_field_control bits, set to match.
// - bit 21 flags network header, bit 20 association header; absent ones take no space.
// - bits 17:16 give device header size: none, 16, 32 or 64 bytes.
// - address authority in bits 63:60 decodes 0..4; others reserved.
// - withdrawn authorities 1100 and 1110 are never sent, treated as undefined.
// - association header is eight words: validity, process and operation associators.
// - validity bits 31..28 flag which associators mean something; 27..25 reserved.
// - fabric answers refused or disabled class 1 preemption with fabric_reject.
// - that reject carries 0x20 if refused, 0x21 if preemption disabled.
// - multicast error codes 0x22, 0x23 come only from the fabric; this block also sends them on control bit 4 (bit 5 picks 0x23).
// - port_busy reason 0x07 means partial multicast busy; others reserved; the classifier also accepts 0x01, 0x03 and 0xff.
module fhp_host (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         irq,
   // frame stream towards the port
   output reg  [31:0] tx_data,
   output reg         tx_valid,
   output reg         tx_last,
   input  wire        tx_ready,
   // frame stream from the port
   input  wire [31:0] rx_data,
   input  wire        rx_valid,
   input  wire        rx_last,
   output reg         rx_ready
);

   localparam [5:0] S_IDLE  = 6'b000001;
   localparam [5:0] S_RSVD  = 6'b000010;
   localparam [5:0] S_NET   = 6'b000100;
   localparam [5:0] S_ASSOC = 6'b001000;
   localparam [5:0] S_DEV   = 6'b010000;
   localparam [5:0] S_PAY   = 6'b100000;

   // software registers
   reg  [5:0]  ctrl;
   reg  [7:0]  hdr_cfg;
   reg  [31:0] net_dest;
   reg  [31:0] net_src;
   reg  [7:0]  validity;
   reg  [7:0]  pay_len;
   reg  [`FHP_EV_W-1:0] int_stat;
   reg  [`FHP_EV_W-1:0] int_mask;
   // transmit side
   reg  [5:0]  state;
   reg  [8:0]  cnt;
   reg  [8:0]  remain;
   reg         go_pend;
   reg         rsp_pend;
   reg  [7:0]  rsp_kind;
   reg  [7:0]  rsp_code;
   reg  [31:0] next_word;
   // receive side
   reg         rx_busy;
   reg  [8:0]  rx_idx;
   reg  [7:0]  rx_kind;
   reg  [7:0]  rx_dfctl;
   reg  [3:0]  rx_dauth;
   reg  [3:0]  rx_sauth;
   reg  [7:0]  rx_valid_byte;
   reg  [7:0]  rx_reason;
   wire        auth_bad;
   wire        code_bad;

   function [8:0] dev_words;
      input [1:0] code;
      begin
         case (code)
            2'b01:   dev_words = 9'd4;
            2'b10:   dev_words = 9'd8;
            2'b11:   dev_words = 9'd16;
            default: dev_words = 9'd0;
         endcase
      end
   endfunction

   function any_hdr;
      input [7:0] cfg;
      begin
         any_hdr = cfg[`FHP_CFG_NET] | cfg[`FHP_CFG_ASSOC] | (|cfg[1:0]);
      end
   endfunction

   // which section follows a given point in the frame
   function [5:0] sec_after;
      input [2:0] lvl;
      input [7:0] cfg;
      begin
         if (lvl == 3'd0 && !any_hdr(cfg))
            sec_after = S_PAY;
         else if (lvl == 3'd0)
            sec_after = S_RSVD;
         else if (lvl <= 3'd1 && cfg[`FHP_CFG_NET])
            sec_after = S_NET;
         else if (lvl <= 3'd2 && cfg[`FHP_CFG_ASSOC])
            sec_after = S_ASSOC;
         else if (lvl <= 3'd3 && (|cfg[1:0]))
            sec_after = S_DEV;
         else
            sec_after = S_PAY;
      end
   endfunction

   // undefined authorities go out as "ignored" so nothing withdrawn leaves
   function [31:0] clean_addr;
      input [31:0] a;
      begin
         if (a[31:28] > `FHP_AUTH_IP)
            clean_addr = {`FHP_AUTH_IGNORED, a[27:0]};
         else
            clean_addr = a;
      end
   endfunction

   // bits 23,22,19,18 stay zero; presence matches what is inserted
   wire [7:0] tx_dfctl = {2'b00, hdr_cfg[`FHP_CFG_NET], hdr_cfg[`FHP_CFG_ASSOC],
                          2'b00, hdr_cfg[1:0]};
   wire [8:0] total = 9'd1 + (any_hdr(hdr_cfg) ? `FHP_RSVD_WORDS : 9'd0)
                    + (hdr_cfg[`FHP_CFG_NET] ? `FHP_NET_WORDS : 9'd0)
                    + (hdr_cfg[`FHP_CFG_ASSOC] ? `FHP_ASSOC_WORDS : 9'd0)
                    + dev_words(hdr_cfg[1:0]) + {1'b0, pay_len};
   wire       advance = !tx_valid || tx_ready;

   always @* begin
      case (state)
         S_RSVD:  next_word = 32'h0000_0000;
         S_NET:
            case (cnt[1:0])
               2'd0:    next_word = clean_addr(net_dest);
               2'd2:    next_word = clean_addr(net_src);
               default: next_word = 32'h0000_0000;
            endcase
         S_ASSOC:
            if (cnt == 9'd0)
               next_word = {validity & `FHP_VALID_RSVD, 24'h000000};
            else
               next_word = 32'h0000_0000;
         S_PAY:   next_word = {23'h000000, cnt};
         default: next_word = 32'h0000_0000;
      endcase
   end

   // apb access and event register
   wire       wr_acc = psel && penable && pwrite;
   wire       setup  = psel && !penable;
   wire       mapped = (paddr <= `FHP_A_INT_MASK) && (paddr[1:0] == 2'b00);
   wire       tx_done_ev = tx_valid && tx_ready && tx_last;
   reg        rx_frame_ev;
   reg        bad_auth_ev;
   reg        bad_code_ev;
   reg        rej_sent_ev;
   reg        mcast_ev;
   wire [`FHP_EV_W-1:0] ev = {mcast_ev, rej_sent_ev, bad_code_ev, bad_auth_ev,
                              rx_frame_ev, tx_done_ev};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata   <= 32'h0000_0000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         irq      <= 1'b0;
         ctrl     <= 6'h00;
         hdr_cfg  <= 8'h00;
         net_dest <= 32'h0000_0000;
         net_src  <= 32'h0000_0000;
         validity <= 8'h00;
         pay_len  <= 8'h00;
         int_stat <= {`FHP_EV_W{1'b0}};
         int_mask <= {`FHP_EV_W{1'b0}};
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         if (setup) begin
            case (paddr)
               `FHP_A_CTRL:     prdata <= {26'h0, ctrl};
               `FHP_A_HDRCFG:   prdata <= {24'h0, hdr_cfg};
               `FHP_A_NET_DEST: prdata <= net_dest;
               `FHP_A_NET_SRC:  prdata <= net_src;
               `FHP_A_VALIDITY: prdata <= {24'h0, validity};
               `FHP_A_PAYLEN:   prdata <= {24'h0, pay_len};
               `FHP_A_RXSTAT:   prdata <= {rx_reason, rx_valid_byte, rx_sauth, rx_dauth,
                                           rx_dfctl};
               `FHP_A_INT_STAT: prdata <= {26'h0, int_stat};
               `FHP_A_INT_MASK: prdata <= {26'h0, int_mask};
               default:         prdata <= 32'h0000_0000;
            endcase
         end
         // command bits 0,3,4 are pulses; bits 1,2 and 5 persist
         ctrl[`FHP_CTRL_START] <= 1'b0;
         ctrl[`FHP_CTRL_BUSY]  <= 1'b0;
         ctrl[`FHP_CTRL_MCERR] <= 1'b0;
         if (wr_acc) begin
            case (paddr)
               `FHP_A_CTRL:     ctrl     <= pwdata[5:0];
               `FHP_A_HDRCFG:   hdr_cfg  <= pwdata[7:0] & 8'h33;
               `FHP_A_NET_DEST: net_dest <= pwdata;
               `FHP_A_NET_SRC:  net_src  <= pwdata;
               `FHP_A_VALIDITY: validity <= pwdata[7:0];
               `FHP_A_PAYLEN:   pay_len  <= pwdata[7:0];
               `FHP_A_INT_MASK: int_mask <= pwdata[`FHP_EV_W-1:0];
               default:         ;
            endcase
         end
         // a new event wins over a write-one clear in the same cycle
         if (wr_acc && paddr == `FHP_A_INT_STAT)
            int_stat <= (int_stat & ~pwdata[`FHP_EV_W-1:0]) | ev;
         else
            int_stat <= int_stat | ev;
         irq <= |(int_stat & int_mask);
      end
   end

   // transmit sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= S_IDLE;
         cnt         <= 9'd0;
         remain      <= 9'd0;
         go_pend     <= 1'b0;
         rsp_pend    <= 1'b0;
         rsp_kind    <= 8'h00;
         rsp_code    <= 8'h00;
         tx_data     <= 32'h0000_0000;
         tx_valid    <= 1'b0;
         tx_last     <= 1'b0;
         rej_sent_ev <= 1'b0;
      end else begin
         rej_sent_ev <= 1'b0;
         if (ctrl[`FHP_CTRL_START])
            go_pend <= 1'b1;
         // later requests overwrite an answer not yet sent
         if (rx_frame_ev && rx_kind == `FHP_K_PREEMPT && !ctrl[`FHP_CTRL_PREEN]) begin
            rsp_pend <= 1'b1;
            rsp_kind <= `FHP_K_REJECT;
            rsp_code <= `FHP_RJ_NOT_EN;
         end else if (rx_frame_ev && rx_kind == `FHP_K_PREEMPT && ctrl[`FHP_CTRL_REFUSE]) begin
            rsp_pend <= 1'b1;
            rsp_kind <= `FHP_K_REJECT;
            rsp_code <= `FHP_RJ_REFUSED;
         end else if (ctrl[`FHP_CTRL_MCERR]) begin
            rsp_pend <= 1'b1;
            rsp_kind <= `FHP_K_REJECT;
            rsp_code <= ctrl[`FHP_CTRL_MCTERM] ? `FHP_RJ_MC_TERM : `FHP_RJ_MC_ERR;
         end else if (ctrl[`FHP_CTRL_BUSY]) begin
            rsp_pend <= 1'b1;
            rsp_kind <= `FHP_K_BUSY;
            rsp_code <= `FHP_BSY_PARTIAL;
         end
         if (advance) begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
         end
         case (state)
            S_IDLE: begin
               if (advance && rsp_pend) begin
                  tx_data     <= {rsp_kind, rsp_code, 16'h0000};
                  tx_valid    <= 1'b1;
                  tx_last     <= 1'b1;
                  rsp_pend    <= 1'b0;
                  rej_sent_ev <= (rsp_kind == `FHP_K_REJECT);
               end else if (advance && go_pend) begin
                  tx_data  <= {`FHP_K_DATA, tx_dfctl, 16'h0000};
                  tx_valid <= 1'b1;
                  tx_last  <= (total == 9'd1);
                  go_pend  <= 1'b0;
                  remain   <= total - 9'd1;
                  cnt      <= 9'd0;
                  if (total != 9'd1)
                     state <= sec_after(3'd0, hdr_cfg);
               end
            end
            S_RSVD, S_NET, S_ASSOC, S_DEV, S_PAY: begin
               if (advance) begin
                  tx_data  <= next_word;
                  tx_valid <= 1'b1;
                  tx_last  <= (remain == 9'd1);
                  remain   <= remain - 9'd1;
                  cnt      <= cnt + 9'd1;
                  if (remain == 9'd1) begin
                     state <= S_IDLE;
                  end else if ((state == S_RSVD && cnt == `FHP_RSVD_WORDS - 9'd1) ||
                               (state == S_NET && cnt == `FHP_NET_WORDS - 9'd1) ||
                               (state == S_ASSOC && cnt == `FHP_ASSOC_WORDS - 9'd1) ||
                               (state == S_DEV && cnt == dev_words(hdr_cfg[1:0]) - 9'd1)) begin
                     cnt <= 9'd0;
                     if (state == S_RSVD)
                        state <= sec_after(3'd1, hdr_cfg);
                     else if (state == S_NET)
                        state <= sec_after(3'd2, hdr_cfg);
                     else if (state == S_ASSOC)
                        state <= sec_after(3'd3, hdr_cfg);
                     else
                        state <= S_PAY;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // receive parser: offsets follow from the first word only
   wire       rx_any   = rx_dfctl[5] | rx_dfctl[4] | (|rx_dfctl[1:0]);
   wire [8:0] net_base = rx_any ? 9'd1 + `FHP_RSVD_WORDS : 9'd1;
   wire [8:0] asc_base = net_base + (rx_dfctl[5] ? `FHP_NET_WORDS : 9'd0);
   wire       rx_take  = rx_valid && rx_ready;
   reg        chk_auth;

   fhp_classify u_classify (
      .dest_auth (rx_dauth),
      .src_auth  (rx_sauth),
      .reason    (rx_reason),
      .kind      (rx_kind),
      .auth_bad  (auth_bad),
      .code_bad  (code_bad)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_ready      <= 1'b0;
         rx_busy       <= 1'b0;
         rx_idx        <= 9'd0;
         rx_kind       <= 8'h00;
         rx_dfctl      <= 8'h00;
         rx_dauth      <= 4'h0;
         rx_sauth      <= 4'h0;
         rx_valid_byte <= 8'h00;
         rx_reason     <= 8'h00;
         rx_frame_ev   <= 1'b0;
         bad_auth_ev   <= 1'b0;
         bad_code_ev   <= 1'b0;
         mcast_ev      <= 1'b0;
         chk_auth      <= 1'b0;
      end else begin
         rx_ready    <= 1'b1;
         rx_frame_ev <= 1'b0;
         mcast_ev    <= 1'b0;
         // classifier reads fields one cycle after the frame closes
         bad_auth_ev <= rx_frame_ev && chk_auth && auth_bad;
         bad_code_ev <= rx_frame_ev && code_bad;
         if (rx_take) begin
            rx_idx  <= rx_busy ? rx_idx + 9'd1 : 9'd1;
            rx_busy <= !rx_last;
            if (!rx_busy) begin
               rx_kind       <= rx_data[31:24];
               rx_dfctl      <= {2'b00, rx_data[21:20], 2'b00, rx_data[17:16]};
               rx_reason     <= rx_data[23:16];
               rx_dauth      <= `FHP_AUTH_IGNORED;
               rx_sauth      <= `FHP_AUTH_IGNORED;
               rx_valid_byte <= 8'h00;
               chk_auth      <= 1'b0;
            end else if (rx_kind == `FHP_K_DATA) begin
               // reserved words and reserved bits are passed over silently
               if (rx_dfctl[5] && rx_idx == net_base) begin
                  rx_dauth <= rx_data[31:28];
                  chk_auth <= 1'b1;
               end
               if (rx_dfctl[5] && rx_idx == net_base + 9'd2)
                  rx_sauth <= rx_data[31:28];
               if (rx_dfctl[4] && rx_idx == asc_base)
                  rx_valid_byte <= rx_data[31:24] & `FHP_VALID_RSVD;
            end
            if (rx_last) begin
               rx_frame_ev <= 1'b1;
               mcast_ev    <= rx_busy && rx_kind == `FHP_K_DATA && rx_dfctl[4] &&
                              rx_idx == asc_base && rx_data[24];
            end
         end
         if (rx_frame_ev && rx_kind == `FHP_K_DATA && rx_valid_byte[0])
            mcast_ev <= 1'b1;
      end
   end

endmodule

/* File: tb/fhp_host_monitor.sv */
`timescale 1ns/100ps
module fhp_host_monitor (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        irq,
   // frame streams
   input wire [31:0] tx_data,
   input wire        tx_valid,
   input wire        tx_last,
   input wire        tx_ready,
   input wire [31:0] rx_data,
   input wire        rx_valid,
   input wire        rx_last,
   input wire        rx_ready
);
   reg [8:0] tx_idx;
   reg [7:0] tx_cfg;
   // word position in frame
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_idx <= 9'h0;
         tx_cfg <= 8'h0;
      end else if (tx_valid && tx_ready) begin
         tx_idx <= tx_last ? 9'h0 : tx_idx + 9'h1;
         if (tx_idx == 9'h0)
            tx_cfg <= tx_data[23:16];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_apb_ready: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_bad_addr: assert property (psel && !penable && (paddr > 8'h20 || paddr[1:0] != 2'h0)
      |=> pslverr) else $error("unmapped address not flagged");
   a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
      && $stable(tx_last)) else $error("tx word changed while stalled");
   a_w0_rsvd: assert property (tx_valid && tx_idx == 9'h0 && tx_data[31:24] == 8'h0
      |-> tx_data[23:22] == 2'h0 && tx_data[19:18] == 2'h0 && tx_data[15:0] == 16'h0)
      else $error("reserved control bits set");
   a_answer_one: assert property (tx_valid && tx_idx == 9'h0 && tx_data[31:24] != 8'h0
      |-> tx_last) else $error("answer frame longer than one word");
   a_reject_code: assert property (tx_valid && tx_idx == 9'h0 && tx_data[31:24] == 8'h02
      |-> tx_data[23:16] >= 8'h20 && tx_data[23:16] <= 8'h23) else $error("bad reject code");
   a_busy_code: assert property (tx_valid && tx_idx == 9'h0 && tx_data[31:24] == 8'h01
      |-> tx_data[23:16] == 8'h07) else $error("bad busy code");
   a_rsvd_zero: assert property (tx_valid && |tx_cfg && tx_idx >= 9'h1 && tx_idx <= 9'h4
      |-> tx_data == 32'h0) else $error("reserved region not zero");
   a_net_auth: assert property (tx_valid && tx_cfg[5] && (tx_idx == 9'h5 || tx_idx == 9'h7)
      |-> tx_data[31:28] <= 4'h4) else $error("withdrawn authority sent");
   a_assoc_rsvd: assert property (tx_valid && tx_cfg[4]
      && tx_idx == (tx_cfg[5] ? 9'h9 : 9'h5) |-> (tx_data & 32'h0eff_ffff) == 32'h0)
      else $error("reserved validity bits set");
   a_no_hdr: assert property (tx_valid && tx_cfg == 8'h0 && tx_idx != 9'h0
      |-> tx_data == {23'h0, tx_idx - 9'h1}) else $error("payload not at first word");
endmodule
bind fhp_host fhp_host_monitor fhp_host_monitor_i (.*);

/* File: tb/fhp_port_model.sv */
`timescale 1ns/100ps
module fhp_port_model (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // frames from the host
   input  wire [31:0] tx_data,
   input  wire        tx_valid,
   input  wire        tx_last,
   output reg         tx_ready,
   // frames to the host
   output reg  [31:0] rx_data,
   output reg         rx_valid,
   output reg         rx_last,
   input  wire        rx_ready,
   // stall control
   input  wire        slow
);
   logic [32:0] got [$];
   int          n_frames = 0;
   initial begin
      rx_valid = 1'b0;
      rx_last = 1'b0;
   end
   always @(posedge pclk) begin
      if (tx_valid && tx_ready) begin
         got.push_back({tx_last, tx_data});
         if (tx_last)
            n_frames++;
      end
      // slow mode stalls every other cycle
      tx_ready <= presetn && !(slow === 1'b1 && tx_ready);
   end
   // caller is just after a rising edge
   task automatic send(input logic [31:0] w [$]);
      foreach (w[i]) begin
         rx_data <= w[i];
         rx_last <= (i == w.size() - 1);
         rx_valid <= 1'b1;
         @(posedge pclk);
         while (rx_ready !== 1'b1)
            @(posedge pclk);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      // released bus shows the inverse
      rx_data <= ~rx_data;
   endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
`include "fhp_consts.vh"
module tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [31:0] tx_data;
   logic        tx_valid;
   logic        tx_last;
   logic        tx_ready;
   logic [31:0] rx_data;
   logic        rx_valid;
   logic        rx_last;
   logic        rx_ready;
   logic        slow;
   int          n_fail = 0;
   int          n_checks = 0;
   fhp_host fhp_host_i (.*);
   fhp_port_model fhp_port_model_i (.*);
   task automatic chkw(input logic [32:0] g, input logic [32:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        er;
      apb(1'b1, a, d, r, er);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input logic ee);
      logic [31:0] r;
      logic        er;
      apb(1'b0, a, 32'h0, r, er);
      chkw({er, r & m}, {ee, e});
   endtask
   task automatic wait_tx(input int n);
      for (int k = 0; k < 3000 && fhp_port_model_i.n_frames < n; k++)
         @(posedge pclk);
      chkw(fhp_port_model_i.n_frames >= n, 1'b1);
   endtask
   task automatic t_tx(input logic [7:0] cfg, input logic [31:0] dst, input logic [7:0] vld,
                       input int len, input logic slw);
      logic [32:0] e [$];
      int          n;
      n = fhp_port_model_i.n_frames;
      @(posedge pclk);
      slow <= slw;
      wr(`FHP_A_HDRCFG, {24'h0, cfg});
      wr(`FHP_A_NET_DEST, dst);
      wr(`FHP_A_NET_SRC, 32'h4000_0055);
      wr(`FHP_A_VALIDITY, {24'h0, vld});
      wr(`FHP_A_PAYLEN, len);
      wr(`FHP_A_CTRL, 32'h1);
      e.push_back({9'h0, cfg & 8'h33, 16'h0});
      if ((cfg & 8'h33) != 8'h0)
         repeat (4) e.push_back(33'h0);
      if (cfg[5]) begin
         e.push_back({1'b0, (dst[31:28] > 4'h4) ? 4'h0 : dst[31:28], dst[27:0]});
         e.push_back(33'h0);
         e.push_back({1'b0, 32'h4000_0055});
         e.push_back(33'h0);
      end
      if (cfg[4]) begin
         e.push_back({1'b0, vld & 8'hf1, 24'h0});
         repeat (7) e.push_back(33'h0);
      end
      if (cfg[1:0] != 2'h0)
         repeat (4 << (cfg[1:0] - 1)) e.push_back(33'h0);
      for (int i = 0; i < len; i++)
         e.push_back({1'b0, i[31:0]});
      e[$][32] = 1'b1;
      wait_tx(n + 1);
      chkw(fhp_port_model_i.got.size(), e.size());
      foreach (e[i])
         chkw(fhp_port_model_i.got[i], e[i]);
      fhp_port_model_i.got.delete();
   endtask
   task automatic t_answer(input logic [7:0] ctl, input logic pre, input logic [15:0] ans);
      logic [31:0] q [$];
      int          n;
      n = fhp_port_model_i.n_frames;
      wr(`FHP_A_CTRL, {24'h0, ctl});
      q.push_back({`FHP_K_PREEMPT, 24'h0});
      if (pre)
         fhp_port_model_i.send(q);
      wait_tx(n + 1);
      chkw(fhp_port_model_i.got.size(), 1);
      chkw(fhp_port_model_i.got[0], {1'b1, ans, 16'h0});
      fhp_port_model_i.got.delete();
   endtask
   task automatic t_rx(input logic [7:0] knd, input logic [7:0] dfc, input logic [3:0] auth,
                       input logic [7:0] vld, input int b, input logic exp);
      logic [31:0] q [$];
      q.push_back({knd, dfc, 16'h0});
      if (knd == `FHP_K_DATA) begin
         repeat (4) q.push_back(32'hffff_ffff);
         if (dfc[5]) begin
            q.push_back({auth, 28'h1});
            q.push_back(32'h0);
            q.push_back({4'h1, 28'h2});
            q.push_back(32'h0);
         end
         if (dfc[4]) begin
            q.push_back({vld, 24'h0});
            repeat (7) q.push_back(32'h0);
         end
         q.push_back(32'h1234);
      end
      fhp_port_model_i.send(q);
      repeat (4) @(posedge pclk);
      rd_chk(`FHP_A_INT_STAT, 32'h1 << b, exp << b, 1'b0);
      wr(`FHP_A_INT_STAT, 32'h3f);
   endtask
   task automatic t_regs;
      rd_chk(`FHP_A_INT_STAT, 32'hffff_ffff, 32'h0, 1'b0);
      rd_chk(8'h24, 32'hffff_ffff, 32'h0, 1'b1);
      rd_chk(8'h06, 32'hffff_ffff, 32'h0, 1'b1);
      wr(`FHP_A_HDRCFG, 32'hff);
      rd_chk(`FHP_A_HDRCFG, 32'hffff_ffff, 32'h33, 1'b0);
   endtask
   task automatic t_irq;
      wr(`FHP_A_INT_STAT, 32'h3e);
      rd_chk(`FHP_A_INT_STAT, 32'h3f, 32'h1, 1'b0);
      chkw(irq, 1'b0);
      wr(`FHP_A_INT_MASK, 32'h1);
      repeat (3) @(posedge pclk);
      chkw(irq, 1'b1);
      wr(`FHP_A_INT_STAT, 32'h1);
      repeat (3) @(posedge pclk);
      chkw(irq, 1'b0);
   endtask
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      #(40 * 60000);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_tx(8'h00, 32'h4000_0001, 8'h00, 3, 1'b0);
      t_irq;
      t_tx(8'h20, 32'hc000_0007, 8'h00, 2, 1'b1);
      t_tx(8'h20, 32'he123_4567, 8'h00, 1, 1'b0);
      t_tx(8'h10, 32'h0, 8'hff, 1, 1'b0);
      t_tx(8'h33, 32'h4000_0009, 8'h0f, 2, 1'b1);
      t_tx(8'h21, 32'h1000_0000, 8'h00, 1, 1'b0);
      t_tx(8'h12, 32'h0, 8'h01, 1, 1'b1);
      t_answer(8'h00, 1'b1, {`FHP_K_REJECT, `FHP_RJ_NOT_EN});
      t_answer(8'h06, 1'b1, {`FHP_K_REJECT, `FHP_RJ_REFUSED});
      t_answer(8'h08, 1'b0, {`FHP_K_BUSY, `FHP_BSY_PARTIAL});
      t_answer(8'h10, 1'b0, {`FHP_K_REJECT, `FHP_RJ_MC_ERR});
      t_answer(8'h30, 1'b0, {`FHP_K_REJECT, `FHP_RJ_MC_TERM});
      for (int a = 0; a < 16; a++)
         t_rx(8'h00, 8'h20, a[3:0], 8'h00, `FHP_EV_BAD_AUTH, a > 4);
      t_rx(8'h00, 8'h10, 4'h0, 8'h01, `FHP_EV_RX_MCAST, 1'b1);
      t_rx(8'h00, 8'h30, 4'h1, 8'hf0, `FHP_EV_RX_MCAST, 1'b0);
      t_rx(8'h00, 8'h10, 4'h0, 8'h0e, `FHP_EV_BAD_CODE, 1'b0);
      t_rx(`FHP_K_BUSY, 8'h07, 4'h0, 8'h00, `FHP_EV_BAD_CODE, 1'b0);
      t_rx(`FHP_K_BUSY, 8'h05, 4'h0, 8'h00, `FHP_EV_BAD_CODE, 1'b1);
      t_rx(`FHP_K_REJECT, 8'h23, 4'h0, 8'h00, `FHP_EV_BAD_CODE, 1'b0);
      t_rx(`FHP_K_REJECT, 8'h24, 4'h0, 8'h00, `FHP_EV_BAD_CODE, 1'b1);
      tally_and_finish;
   end
endmodule
